/* rtl/src_pkg.sv */
// Shared constants and types of the system reset controller.
// Assumes a 32-bit AXI4-Lite register port and one master clock.
package src_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  REG_CTRL        = 4'h0;
    localparam logic [3:0]  REG_STATUS      = 4'h4;
    localparam logic [3:0]  REG_MODE        = 4'h8;
    localparam logic [7:0]  WR_KEY          = 8'hA5;
    localparam int          KEY_LSB         = 24;
    localparam logic [3:0]  STRB_FULL       = 4'hF;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int          CR_CPU_BIT      = 0;
    localparam int          CR_PERIPH_BIT   = 2;
    localparam int          CR_PIN_BIT      = 3;
    localparam int          SR_SEEN_BIT     = 0;
    localparam int          SR_CAUSE_LSB    = 8;
    localparam int          SR_LEVEL_BIT    = 16;
    localparam int          SR_PEND_BIT     = 17;
    localparam int          MR_EN_BIT       = 0;
    localparam int          MR_IRQ_EN_BIT   = 4;
    localparam int          MR_LEN_LSB      = 8;
    localparam int          LEN_W           = 4;

    // ------------------------------------------------------------
    // Reset causes and timing
    // ------------------------------------------------------------
    localparam logic [2:0]  CAUSE_GENERAL   = 3'h0;
    localparam logic [2:0]  CAUSE_BACKUP    = 3'h1;
    localparam logic [2:0]  CAUSE_WDOG      = 3'h2;
    localparam logic [2:0]  CAUSE_SOFT      = 3'h3;
    localparam logic [2:0]  CAUSE_USER      = 3'h4;
    localparam int          EXT_W           = 17;
    localparam logic [EXT_W-1:0] EXT_ONE    = 17'h00001;
    localparam logic [EXT_W-1:0] EXT_GEN    = 17'h00002;
    localparam logic [1:0]  CNT_LAST        = 2'h2;

    typedef enum logic [2:0] {
        ST_IDLE, ST_GEN, ST_BACKUP, ST_WDOG, ST_SW, ST_USER
    } src_state_t;

    typedef struct packed {
        logic              s1, s2, s3, slowLvl;
        logic              n1, n2, n3, pinLvl;
        logic [1:0]        pinSlow;
        src_state_t        st;
        logic [1:0]        cnt;
        logic [EXT_W-1:0]  extCnt;
        logic              extMask;
        logic              swPend, swProc, swPer, wdCpu;
        logic              procAct, perAct, seen;
        logic [2:0]        cause, pendCause;
        logic              pin_reset_enable, pin_reset_irq_enable;
        logic [LEN_W-1:0]  ext_reset_len_exp;
        logic              awHeld, wHeld, bvalid, rvalid;
        logic [ADDR_W-1:0] awAddr;
        logic [31:0]       wData, rdata;
        logic [3:0]        wStrb;
        logic [1:0]        bresp, rresp;
    } src_regs_t;

endpackage

/* rtl/src_reset_ctrl.sv */
// System reset controller: reset arbitration, pin shaping, cause record.
// Assumes slowRefClock and the reset pin are asynchronous to mclk; the
// supply, backup and watchdog inputs come from logic on mclk.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps

module src_reset_ctrl
    import src_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // Slow reference clock, sampled as a level
    input  wire logic        slowRefClock,
    // Supply controller and watchdog
    input  wire logic        coreSupplyResetN,
    input  wire logic        backupReturnReset,
    input  wire logic        chipOffMode,
    input  wire logic        wdogFault,
    input  wire logic        wdogCpuOnly,
    input  wire logic        wdogResetEnable,
    // Reset outputs
    output logic             procResetN,
    output logic             periphResetN,
    output logic             cpuClockEn,
    output logic             rstcIrq,
    // External reset pin
    input  wire logic        nrstIn,
    output logic             nrstOut,
    output logic             nrstOe,
    // AXI4-Lite write
    input  wire logic [31:0] awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    // AXI4-Lite read
    input  wire logic [31:0] araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    localparam src_regs_t RST_STATE = '{
        s1: 1'b0, s2: 1'b0, s3: 1'b0, slowLvl: 1'b0,
        n1: 1'b1, n2: 1'b1, n3: 1'b1, pinLvl: 1'b1,
        pinSlow: 2'h3, st: ST_GEN, cnt: 2'h0, extCnt: EXT_GEN,
        extMask: 1'b1, swPend: 1'b0, swProc: 1'b0, swPer: 1'b0,
        wdCpu: 1'b0, procAct: 1'b1, perAct: 1'b1, seen: 1'b0,
        cause: CAUSE_GENERAL, pendCause: CAUSE_GENERAL,
        pin_reset_enable: 1'b0, pin_reset_irq_enable: 1'b0, ext_reset_len_exp: 4'h0,
        awHeld: 1'b0, wHeld: 1'b0, bvalid: 1'b0, rvalid: 1'b0,
        awAddr: 4'h0, wData: 32'h00000000, rdata: 32'h00000000,
        wStrb: 4'h0, bresp: 2'h0, rresp: 2'h0
    };

    src_regs_t        q;
    src_regs_t        next_q;
    logic             tick;
    logic             doWrite;
    logic             keyOk;
    logic             swCmd;
    logic             userTrig;
    logic             extLoad;
    logic             stepOk;
    logic             clrSeen;
    logic [EXT_W-1:0] extLen;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_q = q;
        stepOk = 1'b0;
        extLoad = 1'b0;
        clrSeen = 1'b0;

        // Slow clock and pin pass three flops; a change counts on agreement
        next_q.s1 = slowRefClock;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (q.s2 == q.s3) begin
            next_q.slowLvl = q.s3;
        end
        tick = !q.slowLvl && next_q.slowLvl;
        next_q.n1 = nrstIn;
        next_q.n2 = q.n1;
        next_q.n3 = q.n2;
        if (q.n2 == q.n3) begin
            next_q.pinLvl = q.n3;
        end
        if (tick) begin
            next_q.pinSlow = {q.pinSlow[0], q.pinLvl};
        end

        // Register bus: address and data taken in either order
        if (awvalid && !q.awHeld) begin
            next_q.awHeld = 1'b1;
            next_q.awAddr = awaddr[ADDR_W-1:0];
        end
        if (wvalid && !q.wHeld) begin
            next_q.wHeld = 1'b1;
            next_q.wData = wdata;
            next_q.wStrb = wstrb;
        end
        if (q.bvalid && bready) begin
            next_q.bvalid = 1'b0;
        end
        doWrite = q.awHeld && q.wHeld && !q.bvalid;
        keyOk = (q.wData[KEY_LSB +: 8] == WR_KEY) && (q.wStrb == STRB_FULL);
        if (doWrite) begin
            next_q.awHeld = 1'b0;
            next_q.wHeld = 1'b0;
            next_q.bvalid = 1'b1;
            next_q.bresp = RESP_OKAY;
            if (q.awAddr != REG_CTRL && q.awAddr != REG_STATUS && q.awAddr != REG_MODE) begin
                next_q.bresp = RESP_SLVERR;
            end
            if (q.awAddr == REG_MODE && keyOk) begin
                next_q.pin_reset_enable = q.wData[MR_EN_BIT];
                next_q.pin_reset_irq_enable = q.wData[MR_IRQ_EN_BIT];
                next_q.ext_reset_len_exp = q.wData[MR_LEN_LSB +: LEN_W];
            end
        end
        // Pending flag or busy state drops the command silently
        swCmd = doWrite && keyOk && (q.awAddr == REG_CTRL) && !q.swPend
              && (q.st == ST_IDLE)
              && (q.wData[CR_CPU_BIT] || q.wData[CR_PERIPH_BIT] || q.wData[CR_PIN_BIT]);

        if (q.rvalid && rready) begin
            next_q.rvalid = 1'b0;
        end
        if (arvalid && !q.rvalid) begin
            next_q.rvalid = 1'b1;
            next_q.rresp = RESP_OKAY;
            next_q.rdata = 32'h00000000;
            unique case (araddr[ADDR_W-1:0])
                REG_CTRL: ;
                REG_STATUS: begin
                    next_q.rdata[SR_SEEN_BIT] = q.seen;
                    next_q.rdata[SR_CAUSE_LSB +: 3] = q.cause;
                    next_q.rdata[SR_LEVEL_BIT] = q.pinLvl;
                    next_q.rdata[SR_PEND_BIT] = q.swPend;
                    clrSeen = 1'b1;
                end
                REG_MODE: begin
                    next_q.rdata[MR_EN_BIT] = q.pin_reset_enable;
                    next_q.rdata[MR_IRQ_EN_BIT] = q.pin_reset_irq_enable;
                    next_q.rdata[MR_LEN_LSB +: LEN_W] = q.ext_reset_len_exp;
                end
                default: next_q.rresp = RESP_SLVERR;
            endcase
        end

        // A new falling edge beats the read clear
        next_q.seen = (q.seen && !clrSeen) || (q.pinLvl && !next_q.pinLvl);

        // Progress of the current reset state
        unique case (q.st)
            ST_IDLE: ;
            ST_GEN:    stepOk = coreSupplyResetN && tick;
            ST_BACKUP: stepOk = !backupReturnReset && tick;
            ST_WDOG:   stepOk = tick;
            ST_SW:     stepOk = tick;
            ST_USER: begin
                // Resync shift must show high before startup count runs
                if (!q.pinSlow[1]) begin
                    next_q.cnt = 2'h0;
                end else begin
                    stepOk = tick;
                end
            end
        endcase
        if (stepOk) begin
            if (q.cnt == CNT_LAST) begin
                next_q.st = ST_IDLE;
                next_q.swPend = 1'b0;
                if (q.procAct) begin
                    next_q.cause = q.pendCause;
                end
            end else begin
                next_q.cnt = q.cnt + 2'h1;
            end
        end

        // Own pulses and their resync tail are masked from user detection
        userTrig = tick && (q.st == ST_IDLE) && q.pin_reset_enable && !q.pinSlow[1]
                 && !q.extMask && (q.extCnt == '0);

        // Entry, highest source first
        if (!coreSupplyResetN) begin
            next_q.st = ST_GEN;
            next_q.cnt = 2'h0;
            next_q.pendCause = CAUSE_GENERAL;
            next_q.swPend = 1'b0;
            next_q.pin_reset_enable = 1'b0;
            next_q.pin_reset_irq_enable = 1'b0;
            next_q.ext_reset_len_exp = 4'h0;
            extLoad = 1'b1;
        end else if (backupReturnReset && q.st != ST_GEN) begin
            next_q.st = ST_BACKUP;
            next_q.cnt = 2'h0;
            next_q.pendCause = CAUSE_BACKUP;
            next_q.swPend = 1'b0;
            extLoad = (q.st != ST_BACKUP);
        end else if (wdogFault && wdogResetEnable
                     && (q.st == ST_IDLE || q.st == ST_SW)) begin
            next_q.st = ST_WDOG;
            next_q.cnt = 2'h0;
            next_q.pendCause = CAUSE_WDOG;
            next_q.wdCpu = wdogCpuOnly;
            next_q.swPend = 1'b0;
            extLoad = !wdogCpuOnly;
        end else if (swCmd) begin
            next_q.st = ST_SW;
            next_q.cnt = 2'h0;
            next_q.pendCause = CAUSE_SOFT;
            next_q.swPend = 1'b1;
            next_q.swProc = q.wData[CR_CPU_BIT];
            next_q.swPer = q.wData[CR_PERIPH_BIT];
            extLoad = q.wData[CR_PIN_BIT];
        end else if (userTrig) begin
            next_q.st = ST_USER;
            next_q.cnt = 2'h0;
            next_q.pendCause = CAUSE_USER;
            extLoad = 1'b1;
        end

        // Pin pulse shaping
        extLen = EXT_ONE << ({1'b0, q.ext_reset_len_exp} + 5'h01);
        if (extLoad) begin
            next_q.extCnt = extLen;
            next_q.extMask = 1'b1;
        end else if (tick && q.extCnt != '0 && coreSupplyResetN) begin
            next_q.extCnt = q.extCnt - EXT_ONE;
        end else if (tick && q.extCnt == '0 && q.pinSlow[1]) begin
            next_q.extMask = 1'b0;
        end

        // Reset lines follow the next state
        unique case (next_q.st)
            ST_IDLE: begin
                next_q.procAct = 1'b0;
                next_q.perAct = 1'b0;
            end
            ST_GEN, ST_BACKUP, ST_USER: begin
                next_q.procAct = 1'b1;
                next_q.perAct = 1'b1;
            end
            ST_WDOG: begin
                next_q.procAct = 1'b1;
                next_q.perAct = !next_q.wdCpu;
            end
            ST_SW: begin
                next_q.procAct = next_q.swProc;
                next_q.perAct = next_q.swPer;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            q <= RST_STATE;
        end else begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign procResetN = !q.procAct;
    assign periphResetN = !q.perAct;
    assign cpuClockEn = !(q.st == ST_USER && !q.pinSlow[1]);
    assign rstcIrq = q.seen && !q.pin_reset_enable && q.pin_reset_irq_enable;
    assign nrstOut = 1'b0;
    // Off mode floats the pin regardless of the pulse counter
    assign nrstOe = (q.extCnt != '0) && !chipOffMode;
    assign awready = !q.awHeld;
    assign wready = !q.wHeld;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign arready = !q.rvalid;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    chk_gen_all_low: assert property (!coreSupplyResetN |=> !procResetN && !periphResetN)
        else $error("supply reset did not assert outputs");
    chk_off_hiz: assert property (chipOffMode |-> !nrstOe)
        else $error("pin driven in off mode");
    chk_key_guard: assert property (doWrite && !keyOk |=> $stable(q.pin_reset_enable) && $stable(q.ext_reset_len_exp))
        else $error("mode changed without key");
    chk_irq_seen: assert property (clrSeen && !(q.pinLvl && !next_q.pinLvl) |=> !rstcIrq)
        else $error("interrupt survived status read");
    chk_fall_sets: assert property ($fell(q.pinLvl) |-> q.seen)
        else $error("pin fall lost");
    chk_sw_assert: assert property (swCmd && q.wData[CR_CPU_BIT] |=> !procResetN ##1 !procResetN)
        else $error("software cpu reset not asserted");
    chk_pend_state: assert property (q.swPend |-> q.st == ST_SW)
        else $error("pending outside software reset");
    chk_user_cause: assert property ($past(q.st) == ST_USER && q.st == ST_IDLE |-> q.cause == CAUSE_USER)
        else $error("user cause not recorded");
    chk_user_disabled: assert property (q.st == ST_IDLE && !q.pin_reset_enable |=> q.st != ST_USER)
        else $error("user reset while disabled");
    chk_wdog_cpu_only: assert property (q.st == ST_WDOG && q.wdCpu |-> q.procAct && !q.perAct)
        else $error("cpu-only watchdog asserted peripherals");

    cov_user: cover property (q.st == ST_USER ##1 q.st == ST_IDLE);
    cov_soft: cover property (swCmd ##1 q.st == ST_SW);
    cov_wdog_preempt: cover property (q.st == ST_SW ##1 q.st == ST_WDOG);

endmodule // src_reset_ctrl

/* test/src_pin_partner.sv */
// Reset line outside the controller: pulled-up wire, outside holder.
// Assumes the controller drives the pin low only while nrstOe is high.
`timescale 1ns/10ps

module src_pin_partner (
    // Controller side
    input  wire logic nrstOe,
    input  wire logic nrstOut,
    // Outside reset source
    input  wire logic holdLow,
    // Line level
    output logic      pinLevel
);
    // ----------------------------------------
    // Wired line
    // ----------------------------------------
    // Released line goes to the pull-up level, never keeps the last value
    // Outside holder wins, so a long external low outlasts our own pulse
    assign pinLevel = holdLow ? 1'b0 : (nrstOe ? nrstOut : 1'b1);
endmodule // src_pin_partner

/* test/system_reset_controller_bench.sv */
// Self-checking bench for the system reset controller.
// Assumes a slow clock of 16 mclk periods and a pulled-up reset line.
`timescale 1ns/10ps

module system_reset_controller_bench import src_pkg::*;;
    localparam logic [31:0] KEYW = {WR_KEY, 24'h0};
    localparam logic [31:0] SWB = (32'h1 << CR_CPU_BIT) | (32'h1 << CR_PERIPH_BIT);
    localparam logic [31:0] PINB = 32'h1 << CR_PIN_BIT;
    logic mclk, reset, slowRefClock, coreSupplyResetN, backupReturnReset, chipOffMode;
    logic wdogFault, wdogCpuOnly, wdogResetEnable, holdLow, nrstIn, nrstOut, nrstOe;
    logic procResetN, periphResetN, cpuClockEn, rstcIrq;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [31:0] awaddr, wdata, araddr, rdata, rdv;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    int failCount, nChecks, n;

    src_reset_ctrl dut_u (.mclk, .reset, .slowRefClock, .coreSupplyResetN, .backupReturnReset,
        .chipOffMode, .wdogFault, .wdogCpuOnly, .wdogResetEnable, .procResetN, .periphResetN,
        .cpuClockEn, .rstcIrq, .nrstIn, .nrstOut, .nrstOe, .awaddr, .awvalid, .awready, .wdata,
        .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready);
    src_pin_partner pin_u (.nrstOe, .nrstOut, .holdLow, .pinLevel(nrstIn));

    // ----------------------------------------
    // Clocks
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        slowRefClock = 1'b0;
        forever #800 slowRefClock = ~slowRefClock;
    end

    // ----------------------------------------
    // Common tasks
    // ----------------------------------------
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic hang(input string what);
        failCount++;
        $display("BAD %s expected done seen timeout", what);
        report_and_stop;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bit done;
        done = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                rs = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("write");
    endtask
    task automatic rd(input logic [31:0] a);
        bit done;
        done = 1'b0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rdv = rdata;
                rs = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
        if (!done) hang("read");
    endtask
    // Waits for procResetN (sel 0) or nrstOe (sel 1) to reach v
    task automatic wait_sig(input int sel, input logic v);
        int i;
        for (i = 0; i < 400; i++) begin
            @(posedge mclk);
            if ((sel == 0 ? procResetN : nrstOe) === v) break;
        end
        if (i == 400) hang("wait");
    endtask
    task automatic pulse_len;
        for (n = 0; nrstOe === 1'b1 && n < 600; n++) @(posedge mclk);
        if (n == 600) hang("pulse");
    endtask
    function automatic logic [31:0] mw(input logic en, input logic irq, input logic [3:0] len);
        return KEYW | (32'(en) << MR_EN_BIT) | (32'(irq) << MR_IRQ_EN_BIT) | (32'(len) << MR_LEN_LSB);
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_boot;
        chk("procN at boot", 1'b0, procResetN);
        wait_sig(0, 1'b1);
        chk("periphN after boot", 1'b1, periphResetN);
        rd(REG_STATUS);
        chk("boot cause", CAUSE_GENERAL, rdv[SR_CAUSE_LSB +: 3]);
        chk("pin level", 1'b1, rdv[SR_LEVEL_BIT]);
        rd(REG_MODE);
        chk("mode reset", 32'h0, rdv);
        rd(32'hC);
        chk("unmapped resp", RESP_SLVERR, rs);
        wr(REG_MODE, 32'h5A000111);
        chk("bad key resp", RESP_OKAY, rs);
        rd(REG_MODE);
        chk("mode bad key", 32'h0, rdv);
        wr(REG_CTRL, 32'h5A000001);
        chk("ctrl bad key", 1'b1, procResetN);
    endtask
    task automatic t_sw;
        wr(REG_CTRL, KEYW | SWB);
        chk("sw procN", 1'b0, procResetN);
        chk("sw periphN", 1'b0, periphResetN);
        rd(REG_STATUS);
        chk("sw pending", 1'b1, rdv[SR_PEND_BIT]);
        chk("cause before release", CAUSE_GENERAL, rdv[SR_CAUSE_LSB +: 3]);
        wr(REG_CTRL, KEYW | PINB);
        chk("write while pending", 1'b0, nrstOe);
        wait_sig(0, 1'b1);
        rd(REG_STATUS);
        chk("sw cause", CAUSE_SOFT, rdv[SR_CAUSE_LSB +: 3]);
        chk("pending cleared", 1'b0, rdv[SR_PEND_BIT]);
    endtask
    task automatic t_pin;
        wr(REG_MODE, mw(1'b1, 1'b0, 4'h1));
        rd(REG_MODE);
        chk("mode readback", 32'h00000101, rdv);
        wr(REG_CTRL, KEYW | PINB);
        pulse_len;
        chk("four tick pulse", 1'b1, n >= 47 && n <= 66);
        repeat (48) @(posedge mclk);
        chk("own pulse no user reset", 1'b1, procResetN);
        rd(REG_STATUS);
        chk("pin only cause", CAUSE_SOFT, rdv[SR_CAUSE_LSB +: 3]);
    endtask
    task automatic t_user;
        holdLow <= 1'b1;
        wait_sig(0, 1'b0);
        chk("user periphN", 1'b0, periphResetN);
        repeat (160) @(posedge mclk);
        chk("held line keeps procN", 1'b0, procResetN);
        chk("cpu clock off", 1'b0, cpuClockEn);
        holdLow <= 1'b0;
        wait_sig(0, 1'b1);
        chk("cpu clock back", 1'b1, cpuClockEn);
        rd(REG_STATUS);
        chk("user cause", CAUSE_USER, rdv[SR_CAUSE_LSB +: 3]);
        chk("seen set", 1'b1, rdv[SR_SEEN_BIT]);
        rd(REG_STATUS);
        chk("seen cleared", 1'b0, rdv[SR_SEEN_BIT]);
        chk("cause kept", CAUSE_USER, rdv[SR_CAUSE_LSB +: 3]);
    endtask
    task automatic t_irq;
        wr(REG_MODE, mw(1'b0, 1'b1, 4'h0));
        holdLow <= 1'b1;
        repeat (48) @(posedge mclk);
        chk("disabled pin procN", 1'b1, procResetN);
        chk("irq raised", 1'b1, rstcIrq);
        rd(REG_STATUS);
        chk("seen on low", 1'b1, rdv[SR_SEEN_BIT]);
        chk("level low", 1'b0, rdv[SR_LEVEL_BIT]);
        chk("irq cleared", 1'b0, rstcIrq);
        holdLow <= 1'b0;
    endtask
    task automatic t_wdog;
        wdogFault <= 1'b1;
        @(posedge mclk);
        wdogFault <= 1'b0;
        repeat (20) @(posedge mclk);
        chk("fault ignored", 1'b1, procResetN);
        wdogResetEnable <= 1'b1;
        wdogCpuOnly <= 1'b1;
        wdogFault <= 1'b1;
        @(posedge mclk);
        wdogFault <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("wdog procN", 1'b0, procResetN);
        chk("wdog periph kept", 1'b1, periphResetN);
        chk("wdog no pin", 1'b0, nrstOe);
        wait_sig(0, 1'b1);
        rd(REG_STATUS);
        chk("wdog cause", CAUSE_WDOG, rdv[SR_CAUSE_LSB +: 3]);
        backupReturnReset <= 1'b1;
        @(posedge mclk);
        backupReturnReset <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("backup procN", 1'b0, procResetN);
        wait_sig(0, 1'b1);
        rd(REG_STATUS);
        chk("backup cause", CAUSE_BACKUP, rdv[SR_CAUSE_LSB +: 3]);
        // Watchdog fault in the middle of a software reset takes over
        wdogCpuOnly <= 1'b0;
        wr(REG_CTRL, KEYW | SWB);
        wdogFault <= 1'b1;
        @(posedge mclk);
        wdogFault <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("preempt pin", 1'b1, nrstOe);
        wait_sig(0, 1'b1);
        rd(REG_STATUS);
        chk("preempt cause", CAUSE_WDOG, rdv[SR_CAUSE_LSB +: 3]);
        chk("preempt pending", 1'b0, rdv[SR_PEND_BIT]);
    endtask
    task automatic t_off_supply;
        chipOffMode <= 1'b1;
        wr(REG_CTRL, KEYW | PINB);
        chk("off pin released", 1'b0, nrstOe);
        chipOffMode <= 1'b0;
        @(posedge mclk);
        chk("pin driven after off", 1'b1, nrstOe);
        wait_sig(1, 1'b0);
        repeat (48) @(posedge mclk);
        wr(REG_MODE, mw(1'b1, 1'b1, 4'h3));
        coreSupplyResetN <= 1'b0;
        repeat (2) @(posedge mclk);
        chk("supply procN", 1'b0, procResetN);
        chk("supply pin", 1'b1, nrstOe);
        coreSupplyResetN <= 1'b1;
        pulse_len;
        chk("two tick pin", 1'b1, n >= 15 && n <= 34);
        wait_sig(0, 1'b1);
        rd(REG_MODE);
        chk("mode cleared", 32'h0, rdv);
        rd(REG_STATUS);
        chk("general cause", CAUSE_GENERAL, rdv[SR_CAUSE_LSB +: 3]);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {failCount, nChecks, n} = '0;
        {reset, coreSupplyResetN} = 2'h3;
        {backupReturnReset, chipOffMode, wdogFault, wdogCpuOnly, wdogResetEnable, holdLow} = '0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, wdata, araddr} = '0;
        wstrb = STRB_FULL;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_boot;
        t_sw;
        t_pin;
        t_user;
        t_irq;
        t_wdog;
        t_off_supply;
        report_and_stop;
    end
endmodule // system_reset_controller_bench
